// >>> hdl/ppm_pkg.sv
// Constants for the peripheral power manager: host offsets, bit fields, timing.
// Assumes a 100 MHz system clock and an 8-bit host port at a fixed base.
package ppm_pkg;
  // Host register offsets, low three address bits
  localparam logic [2:0] OFS_STATUS_A = 3'h0;
  localparam logic [2:0] OFS_STATUS_B = 3'h1;
  localparam logic [2:0] OFS_DRV_OUT  = 3'h2;
  localparam logic [2:0] OFS_MAIN_RATE = 3'h4;
  localparam logic [2:0] OFS_CMD_DATA = 3'h5;
  localparam logic [2:0] OFS_DIN_CFG  = 3'h7;
  // Drive output control fields
  localparam int DOR_RESET_N_BIT = 2;
  localparam int DOR_MOTOR_BIT   = 4;
  // Rate select field
  localparam int DSR_SWRESET_BIT = 7;
  // Auto power configuration fields
  localparam int APC_FLOPPY_BIT  = 0;
  localparam int APC_PAR_BIT     = 3;
  localparam int APC_SER_A_BIT   = 4;
  localparam int APC_SER_B_BIT   = 5;
  // Idle main status value
  localparam logic [7:0] MAIN_IDLE = 8'h80;
  // Extended control modes
  localparam logic [2:0] ECR_SPP   = 3'h0;
  localparam logic [2:0] ECR_BIDIR = 3'h1;
  localparam logic [2:0] ECR_EPP   = 3'h4;
  // Reset values
  localparam logic [7:0] DOR_RESET = 8'h00;
  localparam logic [7:0] DSR_RESET = 8'h02;
  localparam logic [7:0] CCR_RESET = 8'h02;
  // Idle time before floppy powerdown
  localparam int CLK_HZ        = 100_000_000;
  localparam int IDLE_MS       = 10;
  localparam int IDLE_CYCLES   = CLK_HZ / 1000 * IDLE_MS;
endpackage

// >>> hdl/ppm_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module ppm_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // Data
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  // Elaboration check: at least one lane
  if (WIDTH < 1)
    $error("WIDTH must be positive");
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Stage chain; only stage two reads stage one
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end
    else
    begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      syncOut <= RESET_VAL;
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_q[i] == s3_q[i])
          syncOut[i] <= s3_q[i];
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/ppm_idle_timer.sv
// Restartable down-counter flagging expiry of the floppy idle period.
// Assumes restart is a same-clock pulse or level.
`timescale 1ns/10ps
`default_nettype none
module ppm_idle_timer #(
  parameter int CYCLES = 1_000_000
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Control
  input  wire logic restart,
  output logic      expired
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count_q;

  // Elaboration check: a zero period could never expire
  if (CYCLES < 1)
    $error("idle timer needs at least one cycle");

  // Count down, hold at zero; restart reloads
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      count_q <= '0;
    else if (restart)
      count_q <= CW'(CYCLES);
    else if (count_q != '0)
      count_q <= count_q - 1'b1;
  end

  // Expired flag registered
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      expired <= 1'b0;
    else
      expired <= !restart && (count_q == CW'(1) || (count_q == '0 && expired));
  end
endmodule
`default_nettype wire

// >>> hdl/ppm_power_manager.sv
// Peripheral power manager: host gating, PLL power, floppy/serial/parallel auto powerdown.
// Assumes a host port on clk_sys with one-cycle read/write strobes, and peripherals on clk_sys.
`timescale 1ns/10ps
`default_nettype none
module ppm_power_manager #(
  parameter int IDLE_CYCLES = ppm_pkg::IDLE_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Supply monitor
  input  wire logic       supply_good,
  // Host port
  input  wire logic [2:0] hostAddr,
  input  wire logic       hostRd,
  input  wire logic       hostWr,
  input  wire logic [7:0] hostWrData,
  output logic      [7:0] hostRdData,
  output logic            hostRdValid,
  // Floppy core status
  input  wire logic [7:0] fdcStatusA,
  input  wire logic [7:0] fdcStatusB,
  input  wire logic [7:0] fdcMainStatus,
  input  wire logic [7:0] fdcDataIn,
  input  wire logic       fdcIntPending,
  input  wire logic       headUnloadDone,
  output logic            fdcDataRd,
  output logic            fdcDataWr,
  output logic      [7:0] fdcDataOut,
  output logic            fdcAsleep,
  output logic      [7:0] driveOutCtrl,
  output logic      [7:0] rateSelect,
  output logic      [7:0] configControl,
  // Floppy drive pins
  input  wire logic       read_stream_n,
  input  wire logic       write_protect_n,
  input  wire logic       track_zero_n,
  input  wire logic       index_pulse_n,
  input  wire logic       disk_changed_n,
  input  wire logic       coreMotorOn_n,
  input  wire logic       coreDriveSel_n,
  input  wire logic       coreWriteStream_n,
  input  wire logic       coreWriteGate_n,
  input  wire logic       coreStepDir_n,
  input  wire logic       coreStep_n,
  input  wire logic       coreHeadSel_n,
  input  wire logic [1:0] coreDensity,
  output logic      [4:0] driveStatusGated,
  output logic            motor_on_n,
  output logic            drive_select_n,
  output logic            write_stream_n,
  output logic            write_gate_n,
  output logic            driveOutEn,
  output logic            step_direction_n,
  output logic            step_pulse_n,
  output logic            head_select_n,
  output logic      [1:0] density_select,
  // Power configuration bits
  input  wire logic       pll_power_off_bit,
  input  wire logic       wake_power_bit,
  input  wire logic [7:0] auto_power_config,
  output logic            pllPowered,
  output logic            pllSettingBad,
  // Serial ports, index 0 = A, 1 = B
  input  wire logic [1:0] transmit_holding_empty,
  input  wire logic [1:0] txShiftEmpty,
  input  wire logic [1:0] rxFifoEmpty,
  input  wire logic [1:0] rxAwaitStart,
  input  wire logic [1:0] transmit_holding_wr,
  input  wire logic [1:0] serial_receive_line,
  input  wire logic       ring_indicate_a_n,
  input  wire logic       ring_indicate_b_n,
  output logic      [1:0] txAsleep,
  output logic      [1:0] rxAsleep,
  output logic      [1:0] ringChange,
  // Parallel port
  input  wire logic       eppEnabled,
  input  wire logic       ecpEnabled,
  input  wire logic [2:0] ecrMode,
  output logic            eppAsleep,
  output logic            ecpAsleep,
  // Wake interface pins
  input  wire logic       keyboard_line,
  input  wire logic       mouse_line,
  input  wire logic       infrared_receive,
  input  wire logic       wakeRequest,
  output logic            wake_event_out_n,
  output logic      [2:0] wakeLinesSync
);
  // Elaboration check: the timer needs a nonzero period
  if (IDLE_CYCLES < 1)
    $error("IDLE_CYCLES must be positive");
  // Pins preset to idle so reset shows no false edge; order: rd wp tr0 idx dc rxB rxA riB riA ir mouse kbd sg
  logic [12:0] pinSync;
  ppm_sync #(.WIDTH(13), .RESET_VAL(13'h1FFE)) uSync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pinIn   ({read_stream_n, write_protect_n, track_zero_n, index_pulse_n, disk_changed_n,
                serial_receive_line, ring_indicate_b_n, ring_indicate_a_n,
                infrared_receive, mouse_line, keyboard_line, supply_good}),
    .syncOut (pinSync)
  );
  logic       supplyGood;
  logic [1:0] rxLine, riLine;
  assign supplyGood = pinSync[0];
  assign riLine     = pinSync[5:4];
  assign rxLine     = pinSync[7:6];
  // Decode gated by supply good
  logic hostOk, rdMain, anyData, wakeWrite, rdNonWake;
  assign hostOk    = supplyGood;
  assign rdMain    = hostOk && hostRd && hostAddr == ppm_pkg::OFS_MAIN_RATE;
  assign anyData   = hostOk && (hostRd || hostWr) && hostAddr == ppm_pkg::OFS_CMD_DATA;
  // Motor or soft reset via output/rate writes wakes; plain writes do not
  assign wakeWrite = hostOk && hostWr &&
    ((hostAddr == ppm_pkg::OFS_DRV_OUT && (hostWrData[ppm_pkg::DOR_MOTOR_BIT] ||
      !hostWrData[ppm_pkg::DOR_RESET_N_BIT])) ||
     (hostAddr == ppm_pkg::OFS_MAIN_RATE && hostWrData[ppm_pkg::DSR_SWRESET_BIT]));
  assign rdNonWake = hostOk && hostRd && !rdMain && !anyData;
  // Shadow writable registers; kept during sleep and visible on wake
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      driveOutCtrl  <= ppm_pkg::DOR_RESET;
      rateSelect    <= ppm_pkg::DSR_RESET;
      configControl <= ppm_pkg::CCR_RESET;
    end
    else if (hostOk && hostWr)
    begin
      case (hostAddr)
        ppm_pkg::OFS_DRV_OUT:   driveOutCtrl  <= hostWrData;
        ppm_pkg::OFS_MAIN_RATE: rateSelect    <= hostWrData;
        ppm_pkg::OFS_DIN_CFG:   configControl <= hostWrData;
        default:                driveOutCtrl  <= driveOutCtrl;
      endcase
    end
  end
  // Read path: true status, no wake for status A/B reads; a main status read wakes
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      hostRdData  <= 8'h00;
      hostRdValid <= 1'b0;
    end
    else
    begin
      hostRdValid <= hostOk && hostRd;
      if (hostOk && hostRd)
      begin
        case (hostAddr)
          ppm_pkg::OFS_STATUS_A:  hostRdData <= fdcStatusA;
          ppm_pkg::OFS_STATUS_B:  hostRdData <= fdcStatusB;
          ppm_pkg::OFS_DRV_OUT:   hostRdData <= driveOutCtrl;
          ppm_pkg::OFS_MAIN_RATE: hostRdData <= fdcMainStatus;
          ppm_pkg::OFS_CMD_DATA:  hostRdData <= fdcDataIn;
          ppm_pkg::OFS_DIN_CFG:   hostRdData <= {!pinSync[8], 7'h00};
          default:                hostRdData <= 8'h00;
        endcase
      end
    end
  end
  // Data port strobes to the core
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      fdcDataRd  <= 1'b0;
      fdcDataWr  <= 1'b0;
      fdcDataOut <= 8'h00;
    end
    else
    begin
      fdcDataRd  <= anyData && hostRd;
      fdcDataWr  <= anyData && hostWr;
      fdcDataOut <= hostWrData;
    end
  end
  // Floppy power state machine
  typedef enum logic [2:0] {
    PPM_AWAKE  = 3'h1,
    PPM_ASLEEP = 3'h2,
    PPM_PEEK   = 3'h4
  } ppm_fdc_t;
  ppm_fdc_t fdcState_q;
  logic     wakeHit, idleOk, timerDone, autoEn;
  assign autoEn  = auto_power_config[ppm_pkg::APC_FLOPPY_BIT];
  assign wakeHit = rdMain || anyData || wakeWrite;
  // Motor bit 4 off, idle status, no interrupt, head unloaded
  assign idleOk  = !driveOutCtrl[ppm_pkg::DOR_MOTOR_BIT] && fdcMainStatus == ppm_pkg::MAIN_IDLE &&
                   !fdcIntPending && headUnloadDone;
  // Timer runs while awake; restarts on wake, activity or disable
  ppm_idle_timer #(.CYCLES(IDLE_CYCLES)) uIdle (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .restart (!autoEn || fdcState_q != PPM_AWAKE || wakeHit),
    .expired (timerDone)
  );
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      fdcState_q <= PPM_AWAKE;
    else
    begin
      case (fdcState_q)
        PPM_AWAKE:
          if (autoEn && timerDone && idleOk && !wakeHit)
            fdcState_q <= PPM_ASLEEP;
        PPM_ASLEEP:
          if (!autoEn || wakeHit)
            fdcState_q <= PPM_AWAKE;
          else if (rdNonWake || (hostOk && hostWr))
            fdcState_q <= PPM_PEEK;
        PPM_PEEK:
          // A waking access right after a peek must not be lost
          fdcState_q <= (!autoEn || wakeHit) ? PPM_AWAKE : PPM_ASLEEP;
        default:
          fdcState_q <= PPM_AWAKE;
      endcase
    end
  end
  // Sleep output; access cycle does not count as awake
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      fdcAsleep <= 1'b0;
    else
      fdcAsleep <= fdcState_q != PPM_AWAKE;
  end
  // Drive pins: float drive outputs, gate inputs; keep local-logic outputs
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      motor_on_n       <= 1'b1;
      drive_select_n   <= 1'b1;
      write_stream_n   <= 1'b1;
      write_gate_n     <= 1'b1;
      driveOutEn       <= 1'b0;
      driveStatusGated <= 5'h1F;
      step_direction_n <= 1'b1;
      step_pulse_n     <= 1'b1;
      head_select_n    <= 1'b1;
      density_select   <= 2'h0;
    end
    else
    begin
      motor_on_n       <= coreMotorOn_n;
      drive_select_n   <= coreDriveSel_n;
      write_stream_n   <= coreWriteStream_n;
      write_gate_n     <= coreWriteGate_n;
      driveOutEn       <= fdcState_q == PPM_AWAKE;
      // Inputs forced inactive so floating lines draw nothing
      driveStatusGated <= (fdcState_q == PPM_AWAKE) ?
        pinSync[12:8] : 5'h1F;
      step_direction_n <= coreStepDir_n;
      step_pulse_n     <= coreStep_n;
      head_select_n    <= coreHeadSel_n;
      density_select   <= coreDensity;
    end
  end
  // PLL power select
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pllPowered    <= 1'b0;
      pllSettingBad <= 1'b0;
    end
    else
    begin
      pllPowered    <= !pll_power_off_bit && !wake_power_bit && supplyGood;
      pllSettingBad <= !pll_power_off_bit && (wake_power_bit || !supplyGood);
    end
  end
  // Serial auto powerdown, one lane per port
  logic [1:0] serEn, rxLinePrev_q, riPrev_q;
  assign serEn = {auto_power_config[ppm_pkg::APC_SER_B_BIT], auto_power_config[ppm_pkg::APC_SER_A_BIT]};
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      txAsleep     <= 2'h0;
      rxAsleep     <= 2'h0;
      rxLinePrev_q <= 2'h3;
      riPrev_q     <= 2'h3;
      ringChange   <= 2'h0;
    end
    else
    begin
      rxLinePrev_q <= rxLine;
      riPrev_q     <= riLine;
      ringChange   <= riLine ^ riPrev_q;
      for (int p = 0; p < 2; p++)
      begin
        // Wake wins over sleep in the same cycle
        if (!serEn[p] || transmit_holding_wr[p])
          txAsleep[p] <= 1'b0;
        else if (transmit_holding_empty[p] && txShiftEmpty[p])
          txAsleep[p] <= 1'b1;
        if (!serEn[p] || rxLine[p] != rxLinePrev_q[p])
          rxAsleep[p] <= 1'b0;
        else if (rxFifoEmpty[p] && rxAwaitStart[p])
          rxAsleep[p] <= 1'b1;
      end
    end
  end
  // Parallel port: recomputed every cycle so mode changes take effect at once
  logic parEn;
  assign parEn = auto_power_config[ppm_pkg::APC_PAR_BIT];
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      eppAsleep <= 1'b0;
      ecpAsleep <= 1'b0;
    end
    else
    begin
      eppAsleep <= parEn && (!eppEnabled || (ecpEnabled && ecrMode != ppm_pkg::ECR_EPP));
      ecpAsleep <= parEn && (!ecpEnabled || ecrMode == ppm_pkg::ECR_SPP ||
                   ecrMode == ppm_pkg::ECR_BIDIR || ecrMode == ppm_pkg::ECR_EPP);
    end
  end
  // Wake pins stay live regardless of supply good
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wake_event_out_n <= 1'b1;
      wakeLinesSync    <= 3'h7;
    end
    else
    begin
      wake_event_out_n <= !wakeRequest;
      wakeLinesSync    <= pinSync[3:1];
    end
  end
endmodule
`default_nettype wire

// >>> tb/ppm_power_manager_properties.sv
// Concurrent checks on the power manager's ports, bound into every instance.
// Assumes one clock domain and a supply_good synchroniser shorter than eight cycles.
`timescale 1ns/10ps
`default_nettype none
module ppm_power_manager_properties #(
  parameter int IDLE_CYCLES = 20
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // Host side
  input wire logic       supply_good,
  input wire logic [2:0] hostAddr,
  input wire logic       hostRd,
  input wire logic       hostRdValid,
  input wire logic       fdcDataWr,
  // Floppy power and pins
  input wire logic       fdcAsleep,
  input wire logic       driveOutEn,
  input wire logic       coreStep_n,
  input wire logic       step_pulse_n,
  // Configuration and status
  input wire logic       pll_power_off_bit,
  input wire logic       wake_power_bit,
  input wire logic [7:0] auto_power_config,
  input wire logic       pllPowered,
  input wire logic [1:0] txAsleep
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // Awake run length; saturates so long runs never wrap
  int awakeCnt;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      awakeCnt <= 0;
    else if (fdcAsleep)
      awakeCnt <= 0;
    else if (awakeCnt < IDLE_CYCLES)
      awakeCnt <= awakeCnt + 1;
  end

  // Supply windows of eight cycles cover the synchroniser delay
  property p_pll_off; pll_power_off_bit |=> !pllPowered; endproperty
  a_pll_off: assert property (p_pll_off) else $error("PLL powered with off bit");
  property p_pll_on; supply_good [*8] ##0 (!pll_power_off_bit && !wake_power_bit) |=> pllPowered; endproperty
  a_pll_on: assert property (p_pll_on) else $error("PLL not powered");
  property p_ignore; (!supply_good) [*8] |-> !hostRdValid && !fdcDataWr; endproperty
  a_ignore: assert property (p_ignore) else $error("host cycle decoded without supply");
  property p_float; fdcAsleep |-> !driveOutEn; endproperty
  a_float: assert property (p_float) else $error("drive outputs driven while asleep");
  property p_step; fdcAsleep |-> step_pulse_n == $past(coreStep_n); endproperty
  a_step: assert property (p_step) else $error("step output frozen while asleep");
  property p_msr_wake; supply_good [*8] ##0 (hostRd && hostAddr == ppm_pkg::OFS_MAIN_RATE) |-> ##[1:3] !fdcAsleep;
  endproperty
  a_msr_wake: assert property (p_msr_wake) else $error("main status read did not wake");
  property p_peek; supply_good [*8] ##0 (hostRd && hostAddr == ppm_pkg::OFS_STATUS_A && fdcAsleep
    && auto_power_config[0]) |=> fdcAsleep [*3]; endproperty
  a_peek: assert property (p_peek) else $error("status read woke the floppy");
  property p_ser_en; !auto_power_config[ppm_pkg::APC_SER_A_BIT] |=> !txAsleep[0]; endproperty
  a_ser_en: assert property (p_ser_en) else $error("serial slept while disabled");
  property p_idle; $rose(fdcAsleep) |-> awakeCnt >= IDLE_CYCLES - 2; endproperty
  a_idle: assert property (p_idle) else $error("floppy slept before idle time");
  c_sleep: cover property ($rose(fdcAsleep));
  c_wake: cover property ($fell(fdcAsleep));
  c_tx: cover property ($rose(txAsleep[0]));
endmodule
bind ppm_power_manager ppm_power_manager_properties #(.IDLE_CYCLES(IDLE_CYCLES)) i_ppm_power_manager_properties (.*);
`default_nettype wire

// >>> tb/ppm_floppy_model.sv
// Behavioural floppy core status and drive lines seen by the power manager.
// Assumes clk_sys only; each command byte keeps the core busy for BUSY cycles.
`timescale 1ns/10ps
`default_nettype none
module ppm_floppy_model #(
  parameter logic [7:0] STATUS_A = 8'hA5,
  parameter int         BUSY     = 8
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Core side
  input  wire logic       fdcDataWr,
  output logic      [7:0] fdcStatusA,
  output logic      [7:0] fdcStatusB,
  output logic      [7:0] fdcMainStatus,
  output logic      [7:0] fdcDataIn,
  output logic            fdcIntPending,
  output logic            headUnloadDone,
  // Drive lines
  output logic            read_stream_n,
  output logic            write_protect_n,
  output logic            track_zero_n,
  output logic            index_pulse_n,
  output logic            disk_changed_n
);
  int busyCnt;
  // Busy window after each command byte
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      busyCnt <= 0;
    else if (fdcDataWr)
      busyCnt <= BUSY;
    else if (busyCnt > 0)
      busyCnt <= busyCnt - 1;
  end
  // Data line never rests, so a stale gated value cannot pass for idle
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      read_stream_n <= 1'h1;
    else
      read_stream_n <= ~read_stream_n;
  end
  // Idle status and unloaded head only once the busy window ends
  assign fdcMainStatus   = (busyCnt > 0) ? 8'h10 : 8'h80;
  assign headUnloadDone  = (busyCnt == 0);
  assign fdcIntPending   = 1'h0;
  assign fdcStatusA      = STATUS_A;
  assign fdcStatusB      = 8'h00;
  assign fdcDataIn       = 8'h3C;
  assign write_protect_n = 1'h0;
  assign track_zero_n    = 1'h1;
  assign index_pulse_n   = 1'h1;
  assign disk_changed_n  = 1'h1;
endmodule
`default_nettype wire

// >>> tb/ppm_power_manager_bench.sv
// Self-checking bench for the power manager with a behavioural floppy core.
// Assumes a short idle period; all pins connect by matching names.
`timescale 1ns/10ps
`default_nettype none
module ppm_power_manager_bench;
  localparam int IDLE = 20;
  localparam logic [7:0] STAT_A = 8'hA5;
  // Stimulus
  logic clk_sys = 1'h0, nrst = 1'h0, supply_good = 1'h0, hostRd = 1'h0, hostWr = 1'h0, wakeRequest = 1'h0;
  logic [2:0] hostAddr = 3'h0, ecrMode = 3'h0;
  logic [7:0] hostWrData = 8'h00, auto_power_config = 8'h00;
  logic coreMotorOn_n = 1'h1, coreDriveSel_n = 1'h1, coreWriteStream_n = 1'h1, coreWriteGate_n = 1'h1;
  logic coreStepDir_n = 1'h1, coreStep_n = 1'h1, coreHeadSel_n = 1'h1, eppEnabled = 1'h0, ecpEnabled = 1'h0;
  logic pll_power_off_bit = 1'h0, wake_power_bit = 1'h0, ring_indicate_a_n = 1'h1, ring_indicate_b_n = 1'h1;
  logic keyboard_line = 1'h1, mouse_line = 1'h1, infrared_receive = 1'h1;
  logic [1:0] coreDensity = 2'h0, transmit_holding_empty = 2'h3, txShiftEmpty = 2'h3, rxFifoEmpty = 2'h3;
  logic [1:0] rxAwaitStart = 2'h3, transmit_holding_wr = 2'h0, serial_receive_line = 2'h3;
  // Observed
  logic [7:0] hostRdData, fdcStatusA, fdcStatusB, fdcMainStatus, fdcDataIn, fdcDataOut, driveOutCtrl;
  logic [7:0] rateSelect, configControl;
  logic hostRdValid, fdcIntPending, headUnloadDone, fdcDataRd, fdcDataWr, fdcAsleep, driveOutEn;
  logic read_stream_n, write_protect_n, track_zero_n, index_pulse_n, disk_changed_n, motor_on_n, drive_select_n;
  logic write_stream_n, write_gate_n, step_direction_n, step_pulse_n, head_select_n, pllPowered, pllSettingBad;
  logic wake_event_out_n, eppAsleep, ecpAsleep;
  logic [4:0] driveStatusGated;
  logic [2:0] wakeLinesSync;
  logic [1:0] density_select, txAsleep, rxAsleep, ringChange;
  int miscompares = 0, total_checks = 0;

  always #5 clk_sys = ~clk_sys;
  ppm_power_manager #(.IDLE_CYCLES(IDLE)) i_ppm_power_manager (.*);
  ppm_floppy_model #(.STATUS_A(STAT_A)) i_ppm_floppy_model (.*);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Host strobes last one cycle; read data is sampled 1 ns after the taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    hostAddr <= a;
    hostWrData <= d;
    hostWr <= 1'h1;
    @(posedge clk_sys);
    hostWr <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    hostAddr <= a;
    hostRd <= 1'h1;
    @(posedge clk_sys);
    hostRd <= 1'h0;
    #1;
    v = hostRdValid;
    d = hostRdData;
  endtask
  // Bounded wait for floppy powerdown, returning the cycles spent
  task automatic wait_sleep(output int n);
    n = 0;
    while (fdcAsleep !== 1'h1 && n < IDLE + 40)
    begin
      tick(1);
      n++;
    end
    chk({7'h0, fdcAsleep}, 8'h01, "asleep");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_supply;
    logic [7:0] d;
    logic       v;
    wr(ppm_pkg::OFS_DRV_OUT, 8'h14);
    rd(ppm_pkg::OFS_CMD_DATA, d, v);
    chk({driveOutCtrl[6:0], v}, 8'h00, "bus ignored");
    @(posedge clk_sys);
    keyboard_line <= 1'h0;
    wakeRequest <= 1'h1;
    tick(8);
    chk({3'h0, pllPowered, wakeLinesSync, wake_event_out_n}, 8'h0C, "wake pins");
    @(posedge clk_sys);
    keyboard_line <= 1'h1;
    wakeRequest <= 1'h0;
    supply_good <= 1'h1;
    tick(8);
  endtask
  task automatic t_pll;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      {pll_power_off_bit, wake_power_bit} <= i[1:0];
      tick(3);
      chk({6'h0, pllSettingBad, pllPowered}, (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : 8'h00, "pll");
    end
  endtask
  task automatic t_floppy;
    logic [7:0] d;
    logic       v;
    int         n;
    @(posedge clk_sys);
    auto_power_config <= 8'h01;
    coreStep_n <= 1'h0;
    coreMotorOn_n <= 1'h0;
    coreHeadSel_n <= 1'h0;
    coreDensity <= 2'h2;
    wait_sleep(n);
    chk({7'h0, n >= IDLE}, 8'h01, "idle time");
    chk({driveOutEn, step_pulse_n, 1'h0, driveStatusGated}, 8'h1F, "pins asleep");
    chk({motor_on_n, drive_select_n, write_stream_n, write_gate_n, step_direction_n, head_select_n,
         density_select}, 8'h7A, "drive lines");
    rd(ppm_pkg::OFS_STATUS_A, d, v);
    chk(d, STAT_A, "status a");
    wr(ppm_pkg::OFS_MAIN_RATE, 8'h01);
    wr(ppm_pkg::OFS_DRV_OUT, 8'h04);
    tick(3);
    chk({fdcAsleep, rateSelect[6:0]}, 8'h81, "peek writes");
    chk(driveOutCtrl, 8'h04, "dor kept");
    wr(ppm_pkg::OFS_DRV_OUT, 8'h14);
    tick(3);
    chk({1'h0, driveStatusGated, fdcAsleep, driveOutEn}, 8'h5D, "motor wake");
    wr(ppm_pkg::OFS_DRV_OUT, 8'h04);
    wait_sleep(n);
    rd(ppm_pkg::OFS_MAIN_RATE, d, v);
    chk(d, 8'h80, "main status");
    tick(IDLE - 4);
    chk({7'h0, fdcAsleep}, 8'h00, "timer restarted");
    wait_sleep(n);
    wr(ppm_pkg::OFS_CMD_DATA, 8'h3C);
    tick(3);
    chk({fdcDataOut[7:1], fdcAsleep}, 8'h3C, "data wake");
    rd(ppm_pkg::OFS_CMD_DATA, d, v);
    chk({d[7:1], fdcDataRd}, 8'h3D, "data read");
    wait_sleep(n);
    chk({7'h0, n >= IDLE - 4}, 8'h01, "sleep again");
  endtask
  task automatic t_serial;
    logic r;
    tick(4);
    chk({4'h0, txAsleep, rxAsleep}, 8'h00, "no auto");
    @(posedge clk_sys);
    auto_power_config <= 8'h30;
    tick(4);
    chk({4'h0, txAsleep, rxAsleep}, 8'h0F, "serial asleep");
    @(posedge clk_sys);
    transmit_holding_wr <= 2'h1;
    transmit_holding_empty <= 2'h2;
    serial_receive_line <= 2'h1;
    rxAwaitStart <= 2'h1;
    @(posedge clk_sys);
    transmit_holding_wr <= 2'h0;
    ring_indicate_a_n <= 1'h0;
    r = 1'h0;
    for (int i = 0; i < 8; i++)
    begin
      tick(1);
      r = r | ringChange[0];
    end
    chk({4'h0, txAsleep, rxAsleep}, 8'h09, "serial wake");
    chk({6'h0, r, rxAsleep[0]}, 8'h03, "ring asleep");
  endtask
  task automatic t_parallel;
    logic [7:0] tbl [6] = '{8'h00, 8'h83, 8'hF1, 8'hEE, 8'hE7, 8'hC1};
    foreach (tbl[i])
    begin
      @(posedge clk_sys);
      auto_power_config <= {4'h0, tbl[i][7], 3'h0};
      eppEnabled <= tbl[i][6];
      ecpEnabled <= tbl[i][5];
      ecrMode <= tbl[i][4:2];
      tick(2);
      chk({6'h0, eppAsleep, ecpAsleep}, {6'h0, tbl[i][1:0]}, "parallel");
    end
  endtask

  initial
  begin
    tick(2);
    chk({driveOutCtrl[7:1], driveOutEn}, 8'h00, "dor reset");
    chk(rateSelect, 8'h02, "dsr reset");
    chk(configControl, 8'h02, "ccr reset");
    repeat (2) @(posedge clk_sys);
    nrst <= 1'h1;
    t_supply;
    t_pll;
    t_floppy;
    t_serial;
    t_parallel;
    finish_test;
  end
  // Whole run is well under a thousand cycles; this is ten times that
  initial
  begin
    #100000;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test;
  end
endmodule
`default_nettype wire
